// ===== hdl/uart_ext_map.svh
`ifndef UART_EXT_MAP_SVH
`define UART_EXT_MAP_SVH
// Register byte offsets.
`define OFS_CTRL       5'h00
`define OFS_DATA       5'h04
`define OFS_STATUS     5'h08
`define OFS_IRQ_MASK   5'h0C
`define OFS_BAUD       5'h10
// Control register fields.
`define CTRL_TX_EN     0
`define CTRL_RX_EN     1
`define CTRL_NINE      2
`define CTRL_LOOP      3
`define CTRL_RX_SRC    4
`define CTRL_DIR       5
`define CTRL_TX_NINTH  6
`define CTRL_EDGE_IE   7
`define CTRL_RESET     8'h00
// Sticky status fields (write one to clear, except ST_TX_EMPTY, which only a data write clears).
`define ST_TX_EMPTY    0
`define ST_TX_DONE     1
`define ST_RDRF        2
`define ST_EDGE        3
`define ST_OVR         4
`define ST_FE          5
`define ST_W           6
// Live status fields.
`define ST_RX_ACTIVE   8
`define ST_RX_NINTH    9
`define ST_RESET       6'h03
// Oversample and baud.
`define OVS            16
`define BAUD_RESET     16'h0000
`endif

// ===== hdl/uart_ext_pkg.sv
package uart_ext_pkg;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } tx_state_e;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_e;
  typedef logic [1:0] resp_t;
endpackage

// ===== hdl/uart_extended_modes.sv
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "uart_ext_map.svh"

module uart_extended_modes
  import uart_ext_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Stop mode request; registers other than the pin synchronizers and rx_prev_reg hold while it is high.
  input  wire logic                  stop_mode,
  // AXI4-Lite slave.
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [4:0]            s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output uart_ext_pkg::resp_t        s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [4:0]            s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output uart_ext_pkg::resp_t        s_axi_rresp,
  // Serial pins.
  input  wire logic                  txd_in,
  output logic                       txd_out,
  output logic                       txd_oe,
  input  wire logic                  rxd_in,
  output logic                       rxd_released,
  // Interrupt and wake.
  output logic                       irq,
  output logic                       wake
);
  import uart_ext_pkg::*;

  logic [7:0]  ctrl_reg;
  logic [15:0] baud_reg;
  logic [6:0]  status_reg;
  logic [6:0]  mask_reg;
  logic [8:0]  tx_buf_reg;
  logic [8:0]  rx_buf_reg;
  logic        run;
  logic        aw_held_reg, w_held_reg;
  logic [4:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        b_pend_reg, r_pend_reg;
  logic [31:0] rdata_reg;
  resp_t       bresp_reg, rresp_reg;
  logic        wr_go, rd_go;
  logic [4:0]  rd_addr;

  // Registers hold still in stop, except the pin synchronizers and rx_prev_reg, which keep sampling.
  assign run = !stop_mode;

  function automatic logic mapped(input logic [4:0] a);
    mapped = (a == `OFS_CTRL) || (a == `OFS_DATA) || (a == `OFS_STATUS) ||
             (a == `OFS_IRQ_MASK) || (a == `OFS_BAUD);
  endfunction

  // Write channel: address and data are taken independently.
  assign s_axi_awready = run && !aw_held_reg && !b_pend_reg;
  assign s_axi_wready  = run && !w_held_reg && !b_pend_reg;
  assign wr_go = run && aw_held_reg && w_held_reg && !b_pend_reg;
  assign s_axi_bvalid = b_pend_reg;
  assign s_axi_bresp  = bresp_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 5'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      b_pend_reg  <= 1'b0;
      bresp_reg   <= 2'b00;
    end else if (run) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        b_pend_reg  <= 1'b1;
        bresp_reg   <= mapped(aw_addr_reg) ? 2'b00 : 2'b10;
      end else if (b_pend_reg && s_axi_bready) begin
        b_pend_reg <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data.
  assign s_axi_arready = run && !r_pend_reg;
  assign rd_go   = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;
  assign s_axi_rvalid = r_pend_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  logic        rx_active;
  logic        rd_data_evt;

  always_ff @(posedge clk) begin
    if (srst) begin
      r_pend_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= 2'b00;
    end else if (run) begin
      if (rd_go) begin
        r_pend_reg <= 1'b1;
        rresp_reg  <= mapped(rd_addr) ? 2'b00 : 2'b10;
        case (rd_addr)
          `OFS_CTRL:     rdata_reg <= {24'h00_0000, ctrl_reg};
          `OFS_DATA:     rdata_reg <= {24'h00_0000, rx_buf_reg[7:0]};
          `OFS_STATUS:   rdata_reg <= {22'h00_0000, rx_buf_reg[8], rx_active, 1'b0,
                                       status_reg};
          `OFS_IRQ_MASK: rdata_reg <= {25'h000_0000, mask_reg};
          `OFS_BAUD:     rdata_reg <= {16'h0000, baud_reg};
          default:       rdata_reg <= 32'h0000_0000;
        endcase
      end else if (r_pend_reg && s_axi_rready) begin
        r_pend_reg <= 1'b0;
      end
    end
  end
  // Reading data consumes the receive buffer.
  assign rd_data_evt = run && rd_go && (rd_addr == `OFS_DATA);

  logic wr_ctrl, wr_data, wr_stat, wr_mask, wr_baud;
  assign wr_ctrl = wr_go && (aw_addr_reg == `OFS_CTRL) && w_strb_reg[0];
  assign wr_data = wr_go && (aw_addr_reg == `OFS_DATA) && w_strb_reg[0];
  assign wr_stat = wr_go && (aw_addr_reg == `OFS_STATUS) && w_strb_reg[0];
  assign wr_mask = wr_go && (aw_addr_reg == `OFS_IRQ_MASK) && w_strb_reg[0];
  assign wr_baud = wr_go && (aw_addr_reg == `OFS_BAUD);

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= `CTRL_RESET;
      mask_reg <= 7'h00;
      baud_reg <= `BAUD_RESET;
    end else begin
      if (wr_ctrl) ctrl_reg <= w_data_reg[7:0];
      if (wr_mask) mask_reg <= w_data_reg[6:0];
      if (wr_baud) begin
        if (w_strb_reg[0]) baud_reg[7:0]  <= w_data_reg[7:0];
        if (w_strb_reg[1]) baud_reg[15:8] <= w_data_reg[15:8];
      end
    end
  end

  logic nine, loop_m, swire, tx_en, rx_en;
  assign tx_en  = ctrl_reg[`CTRL_TX_EN];
  assign rx_en  = ctrl_reg[`CTRL_RX_EN];
  assign nine   = ctrl_reg[`CTRL_NINE];
  assign loop_m = ctrl_reg[`CTRL_LOOP] && !ctrl_reg[`CTRL_RX_SRC];
  assign swire  = ctrl_reg[`CTRL_LOOP] && ctrl_reg[`CTRL_RX_SRC];

  // Oversample tick divider; a baud value of zero holds it off.
  // A baud write restarts the count, so a new rate never waits out a stale count.
  logic [15:0] div_reg;
  logic        tick;
  assign tick = run && (baud_reg != 16'h0000) && (div_reg == 16'h0000);
  always_ff @(posedge clk) begin
    if (srst || wr_baud) div_reg <= 16'h0000;
    else if (run && (baud_reg != 16'h0000))
      div_reg <= (div_reg == 16'h0000) ? baud_reg - 16'h0001 : div_reg - 16'h0001;
  end

  // Transmitter.
  tx_state_e   tx_st_reg;
  logic [8:0]  tx_sh_reg;
  logic [3:0]  tx_bit_reg, tx_ph_reg;
  logic        tx_line, tx_load, tx_done;
  logic        tx_empty;
  assign tx_empty = status_reg[`ST_TX_EMPTY];
  assign tx_load  = tick && tx_en && (tx_st_reg == TX_IDLE) && !tx_empty;
  assign tx_done = tick && (tx_st_reg == TX_STOP) && (tx_ph_reg == 4'hF);
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_st_reg <= TX_IDLE;
      tx_sh_reg <= 9'h000;
      tx_bit_reg <= 4'h0;
      tx_ph_reg <= 4'h0;
      tx_line <= 1'b1;
    end else if (tick) begin
      tx_ph_reg <= tx_ph_reg + 4'h1;
      case (tx_st_reg)
        TX_IDLE: begin
          tx_line <= 1'b1;
          tx_ph_reg <= 4'h0;
          if (tx_load) begin
            tx_sh_reg <= tx_buf_reg;
            tx_st_reg <= TX_START;
            tx_line <= 1'b0;
          end
        end
        TX_START: if (tx_ph_reg == 4'hF) begin
          tx_st_reg <= TX_DATA;
          tx_bit_reg <= 4'h0;
          tx_line <= tx_sh_reg[0];
        end
        TX_DATA: if (tx_ph_reg == 4'hF) begin
          if (tx_bit_reg == (nine ? 4'h8 : 4'h7)) begin
            tx_st_reg <= TX_STOP;
            tx_line <= 1'b1;
          end else begin
            tx_bit_reg <= tx_bit_reg + 4'h1;
            tx_line <= tx_sh_reg[tx_bit_reg + 4'h1];
          end
        end
        TX_STOP: if (tx_ph_reg == 4'hF) tx_st_reg <= TX_IDLE;
        default: tx_st_reg <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) tx_buf_reg <= 9'h000;
    else if (wr_ctrl) tx_buf_reg[8] <= w_data_reg[`CTRL_TX_NINTH];
    else if (wr_data) tx_buf_reg[7:0] <= w_data_reg[7:0];
  end

  // Pin routing for loop and single-wire operation.
  logic rx_pin_s1, rx_pin_s2, tx_pin_s1, tx_pin_s2, rx_src, drive_tx;
  always_ff @(posedge clk) begin
    rx_pin_s1 <= rxd_in;
    rx_pin_s2 <= rx_pin_s1;
    tx_pin_s1 <= txd_in;
    tx_pin_s2 <= tx_pin_s1;
  end
  assign drive_tx = tx_en && (!swire || ctrl_reg[`CTRL_DIR]);
  assign txd_out = tx_line;
  assign txd_oe  = drive_tx;
  assign rxd_released = swire;
  always_comb begin
    if (loop_m) rx_src = tx_line;
    else if (swire) rx_src = drive_tx ? tx_line : tx_pin_s2;
    else rx_src = rx_pin_s2;
  end

  // Receiver.
  rx_state_e  rx_st_reg;
  logic [8:0] rx_sh_reg;
  logic [3:0] rx_bit_reg, rx_ph_reg;
  logic       rx_prev_reg, rx_edge, rx_got;
  assign rx_active = (rx_st_reg != RX_IDLE);
  assign rx_edge = rx_en && rx_prev_reg && !rx_src;
  assign rx_got = tick && (rx_st_reg == RX_STOP) && (rx_ph_reg == 4'h7);
  always_ff @(posedge clk) begin
    if (srst) rx_prev_reg <= 1'b1;
    else rx_prev_reg <= rx_src;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_st_reg <= RX_IDLE;
      rx_sh_reg <= 9'h000;
      rx_bit_reg <= 4'h0;
      rx_ph_reg <= 4'h0;
    end else if (tick) begin
      rx_ph_reg <= rx_ph_reg + 4'h1;
      case (rx_st_reg)
        RX_IDLE: begin
          rx_ph_reg <= 4'h0;
          if (rx_en && !rx_src) rx_st_reg <= RX_START;
        end
        RX_START: if (rx_ph_reg == 4'h7) begin
          rx_ph_reg <= 4'h0;
          rx_bit_reg <= 4'h0;
          rx_sh_reg <= 9'h000;
          rx_st_reg <= rx_src ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_ph_reg == 4'hF) begin
          rx_sh_reg[rx_bit_reg] <= rx_src;
          if (rx_bit_reg == (nine ? 4'h8 : 4'h7)) rx_st_reg <= RX_STOP;
          rx_bit_reg <= rx_bit_reg + 4'h1;
        end
        RX_STOP: if (rx_ph_reg == 4'h7) rx_st_reg <= RX_IDLE;
        default: rx_st_reg <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) rx_buf_reg <= 9'h000;
    else if (rx_got && !status_reg[`ST_RDRF]) rx_buf_reg <= {nine & rx_sh_reg[8],
                                                             rx_sh_reg[7:0]};
  end

  // Sticky status; a hardware set in the same cycle beats the software clear.
  logic [6:0] set_v, clr_v;
  always_comb begin
    set_v = 7'h00;
    set_v[`ST_TX_EMPTY] = tx_load;
    set_v[`ST_TX_DONE]  = tx_done && tx_empty;
    set_v[`ST_RDRF] = rx_got && !status_reg[`ST_RDRF];
    set_v[`ST_EDGE] = rx_edge && run;
    set_v[`ST_OVR]  = rx_got && status_reg[`ST_RDRF];
    set_v[`ST_FE]   = rx_got && !rx_src;
    set_v[`ST_W]    = 1'b0;
    clr_v = wr_stat ? w_data_reg[6:0] : 7'h00;
    clr_v[`ST_TX_EMPTY] = wr_data;
    clr_v[`ST_TX_DONE]  = wr_data || (wr_stat && w_data_reg[`ST_TX_DONE]);
    clr_v[`ST_RDRF] = rd_data_evt || (wr_stat && w_data_reg[`ST_RDRF]);
  end
  always_ff @(posedge clk) begin
    if (srst) status_reg <= {1'b0, `ST_RESET};
    else status_reg <= (status_reg & ~clr_v) | set_v;
  end

  assign irq = |(status_reg & mask_reg);
  // The edge detector stays alive while the other registers hold in stop, so wake is combinational.
  assign wake = stop_mode && rx_en && ctrl_reg[`CTRL_EDGE_IE] &&
                rx_prev_reg && !rx_src;

  sequence s_load;
    tx_load;
  endsequence
  a_tx_ninth_copy: assert property (@(posedge clk) disable iff (srst)
    s_load |=> tx_sh_reg[8] == $past(tx_buf_reg[8])) else $error("ninth bit not copied");
  a_stop_hold: assert property (@(posedge clk) disable iff (srst)
    stop_mode |=> $stable(ctrl_reg) && $stable(tx_st_reg)) else $error("state moved in stop");
  a_loop_route: assert property (@(posedge clk) disable iff (srst)
    loop_m |-> rx_src == tx_line) else $error("loop route wrong");
  a_swire_dir: assert property (@(posedge clk) disable iff (srst)
    swire && !ctrl_reg[`CTRL_DIR] |-> !txd_oe) else $error("tx driven in receive");
  a_swire_release: assert property (@(posedge clk) disable iff (srst)
    swire |-> rxd_released) else $error("rx pin not released");
  a_edge_flag: assert property (@(posedge clk) disable iff (srst)
    rx_edge && run |=> status_reg[`ST_EDGE]) else $error("edge flag missed");
  a_wake_gate: assert property (@(posedge clk) disable iff (srst)
    wake |-> ctrl_reg[`CTRL_EDGE_IE] && stop_mode) else $error("wake while masked");
  a_nine_bits: assert property (@(posedge clk) disable iff (srst)
    !nine && rx_got |=> !rx_buf_reg[8] || $stable(rx_buf_reg)) else $error("ninth bit leak");
  a_mode_sel: assert property (@(posedge clk) disable iff (srst)
    ctrl_reg[`CTRL_LOOP] |-> loop_m != swire) else $error("mode select wrong");
endmodule

// ===== bench/remote_uart.sv
`timescale 1ns/1ps
module remote_uart #(
  parameter int BIT = 16
) (
  // Serial line.
  input  wire logic line_in,
  output logic      line_out,
  // Clock.
  input  wire logic clk
);
  int         nbits  = 8;
  bit         listen = 0;
  logic [8:0] rq[$];
  initial line_out = 1'b1;
  // Frames go out LSB first with one stop bit; the line idles high between them.
  task automatic send(input logic [8:0] d);
    line_out <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      line_out <= d[i];
      repeat (BIT) @(posedge clk);
    end
    line_out <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  // Samples mid-bit, so a receiver a little off in phase still reads clean bits.
  always begin : rx
    logic [8:0] d;
    @(negedge line_in);
    d = '0;
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT) @(posedge clk);
      d[i] = line_in;
    end
    repeat (BIT) @(posedge clk);
    if (listen) rq.push_back(d);
  end
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`include "uart_ext_map.svh"
module tb_top;
  import uart_ext_pkg::*;
  logic        clk = 0;
  logic        srst = 1;
  logic        stop_mode = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  resp_t       s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rv;
  logic        txd_in = 1, rxd_in = 1, txd_out, txd_oe, rxd_released, irq, wake;
  logic        noise = 0, on_pin = 0, seen_w, seen_r;
  logic [7:0]  d;
  logic [8:0]  eq[$];
  wire         rem_out;
  wire         pin = txd_oe ? txd_out : (on_pin ? rem_out : 1'b1);
  int          bad_count = 0, check_count = 0;

  uart_extended_modes DUT (.clk, .srst, .stop_mode, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .txd_in, .txd_out, .txd_oe,
    .rxd_in, .rxd_released, .irq, .wake);
  remote_uart #(.BIT(16)) rem (.clk(clk), .line_in(pin), .line_out(rem_out));

  always #2.5 clk = ~clk;
  // Noise on the receive pin must not reach the receiver in loop mode.
  always @(posedge clk) begin
    txd_in <= pin;
    rxd_in <= noise ? 1'($urandom) : (on_pin ? 1'b1 : rem_out);
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic ta, tw, ok;
    @(posedge clk);
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_bready <= 1;
    forever begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      ok = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (ok) break;
    end
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [4:0] a);
    logic ta, ok;
    @(posedge clk);
    s_axi_arvalid <= 1;
    s_axi_araddr <= a;
    s_axi_rready <= 1;
    forever begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      ok = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 0;
      if (ok) break;
    end
    s_axi_rready <= 0;
  endtask
  // Polls status until the given bit is set; rv keeps that status word.
  task automatic wait_st(input int b);
    for (int i = 0; i < 600; i++) begin
      rd(`OFS_STATUS);
      if (rv[b] === 1'b1) return;
    end
    chk("status wait", 1, 0);
  endtask
  task automatic rx_chk(input string nm);
    logic r8;
    wait_st(`ST_RDRF);
    r8 = rv[`ST_RX_NINTH];
    rd(`OFS_DATA);
    chk(nm, 32'(eq.pop_front()), {23'h0, r8, rv[7:0]});
  endtask
  task automatic final_report;
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    final_report;
  end

  initial begin
    void'($urandom(91081));
    repeat (2) @(posedge clk);
    srst <= 0;
    rd(`OFS_CTRL);
    chk("ctrl reset", 0, rv);
    rd(`OFS_STATUS);
    chk("status reset", 32'h0000_0003, rv);
    rd(5'h14);
    chk("unmapped resp", 2, 32'(rr));
    chk("unmapped data", 0, rv);
    wr(5'h14, 32'h0000_0000);
    chk("unmapped wr resp", 2, 32'(rr));
    wr(`OFS_BAUD, 1);
    chk("baud wr resp", 0, 32'(rr));
    // Loop mode, nine bits; the ninth bit is set, reused for the second character, then cleared for the third.
    noise <= 1;
    for (int k = 0; k < 3; k++) begin
      if (k != 1) wr(`OFS_CTRL, k == 0 ? 8'h4F : 8'h0F);
      d = 8'($urandom);
      eq.push_back({1'(k < 2), d});
      wr(`OFS_DATA, {24'h0, d});
      rx_chk("loop char");
    end
    // Normal mode against the remote side, with the edge flag raising irq.
    @(posedge clk);
    noise <= 0;
    rem.nbits = 9;
    rem.listen = 1;
    wr(`OFS_CTRL, 8'h47);
    wr(`OFS_STATUS, 8'h7F);
    wr(`OFS_IRQ_MASK, 8'h08);
    d = 8'($urandom);
    wr(`OFS_DATA, {24'h0, d});
    for (int i = 0; i < 400 && rem.rq.size() == 0; i++) @(posedge clk);
    chk("remote rx", {1'b1, d}, rem.rq.size() ? 32'(rem.rq.pop_front()) : 32'hFFFF);
    rem.listen = 0;
    d = 8'($urandom);
    eq.push_back({1'b0, d});
    rem.send({1'b0, d});
    rx_chk("remote tx");
    rd(`OFS_STATUS);
    chk("edge flag", 1, rv[`ST_EDGE]);
    @(negedge clk);
    chk("irq on", 1, irq);
    wr(`OFS_STATUS, 8'h08);
    rd(`OFS_STATUS);
    chk("edge clear", 0, rv[`ST_EDGE]);
    @(negedge clk);
    chk("irq off", 0, irq);
    wr(`OFS_IRQ_MASK, 0);
    // Single wire, receiving from the tx pin, then sending on it.
    wr(`OFS_CTRL, 8'h5F);
    @(negedge clk);
    chk("tx pin enable", 0, txd_oe);
    chk("rx released", 1, rxd_released);
    @(posedge clk);
    on_pin <= 1;
    @(posedge clk);
    d = 8'($urandom);
    eq.push_back({1'b1, d});
    rem.send({1'b1, d});
    rx_chk("wire rx");
    wr(`OFS_CTRL, 8'h7F);
    d = 8'($urandom);
    eq.push_back({1'b1, d});
    wr(`OFS_DATA, {24'h0, d});
    for (int i = 0; i < 40 && txd_oe !== 1'b1; i++) @(negedge clk);
    chk("tx pin drive", 1, txd_oe);
    rx_chk("wire echo");
    // Stop mode only once idle; an edge must wake it and state must hold.
    @(posedge clk);
    on_pin <= 0;
    rem.nbits = 8;
    wr(`OFS_CTRL, 8'h82);
    // Software waits for the last stop bit to finish before it may stop.
    wait_st(`ST_TX_DONE);
    chk("idle before stop", 32'h0000_0003, rv & 32'h0000_0103);
    @(posedge clk);
    stop_mode <= 1;
    seen_w = 0;
    seen_r = 0;
    @(posedge clk);
    fork
      rem.send(9'h0F0);
      for (int i = 0; i < 150; i++) begin
        @(negedge clk);
        seen_w |= wake;
        seen_r |= s_axi_arready;
      end
    join
    chk("wake", 1, seen_w);
    chk("ready in stop", 0, seen_r);
    stop_mode <= 0;
    rd(`OFS_CTRL);
    chk("ctrl kept", 32'h0000_0082, rv);
    rd(`OFS_BAUD);
    chk("baud kept", 1, rv);
    final_report;
  end
endmodule
